// ### dv/gfst_far_side.sv
// Far-side model: sense transformer level, mains phase and comparator
`timescale 1ns/100ps
module gfst_far_side #(
    parameter int HALF_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic test_inject,
    input wire logic [7:0] inj_code,
    input wire logic [7:0] gf_code,
    input wire logic big_fault,
    output logic [7:0] fault_level,
    output logic mains_zc,
    output logic over_200mv
);
    int ph = 0;
    initial mains_zc = 1'b0;
    // Mains runs free, so the phase pin never stalls
    always @(posedge clk_sys) begin
        ph <= (ph == HALF_CYC - 1) ? 0 : ph + 1;
        if (ph == HALF_CYC - 1) mains_zc <= ~mains_zc;
    end
    // Injected test current is what the transformer sees during a test
    assign fault_level = test_inject ? inj_code : gf_code;
    assign over_200mv = big_fault;
endmodule : gfst_far_side

// ### dv/ground_fault_self_test_trip_tb.sv
// Self-checking bench for the self-test and trip sequencer
`timescale 1ns/100ps
module ground_fault_self_test_trip_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] inj_code = 8'h00;
    logic [7:0] gf_code = 8'h00;
    logic big_fault = 1'b0;
    logic [7:0] fault_level;
    logic mains_zc, over_200mv, test_inject, trip_driver, fault_blink;
    logic [2:0] fail_count;
    int n_fail = 0;
    int num_checks = 0;
    initial forever #50 clk_sys = ~clk_sys;
    // Pass interval kept above the longest graded delay so no test masks it
    gfst_top #(.CYC_PER_MS(10), .HF_CYC(20), .RETRY_MS(5), .PASS_MS(170)) uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .fault_level(fault_level),
        .mains_zc(mains_zc), .over_200mv(over_200mv), .test_inject(test_inject),
        .trip_driver(trip_driver), .fault_blink(fault_blink), .fail_count(fail_count));
    gfst_far_side #(.HALF_CYC(8)) far (
        .clk_sys(clk_sys), .test_inject(test_inject), .inj_code(inj_code),
        .gf_code(gf_code), .big_fault(big_fault), .fault_level(fault_level),
        .mains_zc(mains_zc), .over_200mv(over_200mv));
    task automatic print_verdict;
        $display("Counts: %0d checks, %0d mismatches", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h range=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    function automatic logic pick(input int w);
        return w == 0 ? test_inject : (w == 1 ? trip_driver : fault_blink);
    endfunction : pick
    // Sampled on falling edges, where outputs have settled
    task automatic wait_for(input int w, input logic lvl, input int lim, output int n);
        n = 0;
        while (pick(w) !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > lim) begin
                n_fail++;
                $display("CHECK FAILED t=%0t wait=%h lvl=%h", $time, w, lvl);
                print_verdict();
            end
        end
    endtask : wait_for
    task automatic do_reset;
        @(posedge clk_sys);
        arst_n <= 1'b0;
        inj_code <= 8'h00;
        gf_code <= 8'h00;
        big_fault <= 1'b0;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
    endtask : do_reset
    task automatic t_fail_run;
        int n;
        do_reset();
        wait_for(0, 1'b1, 20, n);
        for (int i = 1; i <= 7; i++) begin
            wait_for(0, 1'b0, 30, n);
            chk_rng(n, 8, 24);
            repeat (3) @(negedge clk_sys);
            chk(fail_count, 16'(i));
            chk(trip_driver, 16'(i == 7));
            wait_for(0, 1'b1, 100, n);
            // Wait is counted in ms ticks, so it runs four to five ms plus judge cycles
            chk_rng(n + 3, 42, 53);
        end
        wait_for(2, 1'b1, 2600, n);
        chk(trip_driver, 16'h0001);
        chk(fail_count, 16'h0007);
        $display("Test done: seven failures");
    endtask : t_fail_run
    task automatic t_pass;
        int n;
        do_reset();
        inj_code <= 8'd61;
        wait_for(0, 1'b1, 20, n);
        wait_for(0, 1'b0, 30, n);
        repeat (3) @(negedge clk_sys);
        chk(fail_count, 16'h0001);
        @(posedge clk_sys);
        inj_code <= 8'd60;
        wait_for(0, 1'b1, 100, n);
        wait_for(0, 1'b0, 30, n);
        repeat (3) @(negedge clk_sys);
        chk(fail_count, 16'h0000);
        wait_for(0, 1'b1, 1800, n);
        chk_rng(n + 3, 1692, 1703);
        $display("Test done: pass window");
    endtask : t_pass
    task automatic t_graded;
        int n;
        logic [7:0] lvl [9] = '{8'd12, 8'd20, 8'd30, 8'd35, 8'd40, 8'd45, 8'd53, 8'd58, 8'd67};
        int lim [9] = '{125, 95, 75, 60, 50, 40, 35, 25, 20};
        for (int b = 0; b < 9; b++) begin
            do_reset();
            inj_code <= 8'd20;
            wait_for(0, 1'b1, 20, n);
            wait_for(0, 1'b0, 30, n);
            @(posedge clk_sys);
            gf_code <= lvl[b];
            @(negedge clk_sys);
            wait_for(1, 1'b1, 1300, n);
            chk_rng(n, (lim[b] - 2) * 10, lim[b] * 10 + 2);
        end
        $display("Test done: graded bands");
    endtask : t_graded
    task automatic t_big;
        int n;
        do_reset();
        inj_code <= 8'd20;
        wait_for(0, 1'b1, 20, n);
        wait_for(0, 1'b0, 30, n);
        @(posedge clk_sys);
        big_fault <= 1'b1;
        repeat (15) @(posedge clk_sys);
        big_fault <= 1'b0;
        repeat (30) @(negedge clk_sys);
        chk(trip_driver, 16'h0000);
        @(posedge clk_sys);
        big_fault <= 1'b1;
        @(negedge clk_sys);
        wait_for(1, 1'b1, 40, n);
        chk_rng(n, 20, 26);
        @(posedge clk_sys);
        big_fault <= 1'b0;
        repeat (100) @(negedge clk_sys);
        chk(trip_driver, 16'h0001);
        $display("Test done: large fault");
    endtask : t_big
    initial begin
        t_fail_run();
        t_pass();
        t_graded();
        t_big();
        print_verdict();
    end
endmodule : ground_fault_self_test_trip_tb

// ### verilog/gfst_pkg.sv
// Constants for the ground-fault self-test and trip sequencer
package gfst_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 10_000_000;
    // Fault level code width; one code step is 0.5 mA
    localparam int unsigned FL_W = 8;
    localparam int unsigned CNT_W = 24;
    // Band lower edges in codes: 6, 10, 15, 17.5, 20, 22.5, 26.5, 29 mA; the top band starts above 33 mA
    localparam logic [7:0] BAND_6MA = 8'h0C;
    localparam logic [7:0] BAND_10MA = 8'h14;
    localparam logic [7:0] BAND_15MA = 8'h1E;
    localparam logic [7:0] BAND_17P5MA = 8'h23;
    localparam logic [7:0] BAND_20MA = 8'h28;
    localparam logic [7:0] BAND_22P5MA = 8'h2D;
    localparam logic [7:0] BAND_26P5MA = 8'h35;
    localparam logic [7:0] BAND_29MA = 8'h3A;
    localparam logic [7:0] BAND_33MA = 8'h42;
    // Longest trip delay per band, in ms
    localparam logic [7:0] LIM_6MA_MS = 8'h7D;
    localparam logic [7:0] LIM_10MA_MS = 8'h5F;
    localparam logic [7:0] LIM_15MA_MS = 8'h4B;
    localparam logic [7:0] LIM_17P5MA_MS = 8'h3C;
    localparam logic [7:0] LIM_20MA_MS = 8'h32;
    localparam logic [7:0] LIM_22P5MA_MS = 8'h28;
    localparam logic [7:0] LIM_26P5MA_MS = 8'h23;
    localparam logic [7:0] LIM_29MA_MS = 8'h19;
    localparam logic [7:0] LIM_33MA_MS = 8'h14;
    // Self-test judgement window: too low below 6 mA, too high above 30 mA
    localparam logic [7:0] TEST_LOW = 8'h0C;
    localparam logic [7:0] TEST_HIGH = 8'h3C;
    localparam logic [1:0] TEST_HALF_CYCLES = 2'h2;
    localparam logic [2:0] FAIL_MAX = 3'h7;
    // Retry and pass intervals in minutes
    localparam int unsigned RETRY_MIN = 1;
    localparam int unsigned PASS_MIN = 17;
    localparam int unsigned MS_PER_MIN = 60_000;
    // Large-fault persistence time, in us
    localparam int unsigned HF_TIME_US = 1400;
    // Indicator blink half period, in ms
    localparam logic [7:0] BLINK_MS = 8'hFA;
    // Reset values
    localparam logic [2:0] FAIL_RST = 3'h0;
    localparam logic [23:0] WAIT_RST = 24'h00_0000;

    typedef enum logic [2:0] {
        GFST_WAIT = 3'b001,
        GFST_TEST = 3'b010,
        GFST_JUDGE = 3'b100
    } gfst_state_e;
endpackage : gfst_pkg

// ### verilog/gfst_top.sv
// Ground-fault self-test scheduler, failure counter and trip decision
`timescale 1ns/100ps
module gfst_top #(
    parameter int unsigned CYC_PER_MS = gfst_pkg::CLK_HZ / 1000,
    parameter int unsigned HF_CYC = gfst_pkg::HF_TIME_US * (gfst_pkg::CLK_HZ / 1_000_000),
    parameter int unsigned RETRY_MS = gfst_pkg::RETRY_MIN * gfst_pkg::MS_PER_MIN,
    parameter int unsigned PASS_MS = gfst_pkg::PASS_MIN * gfst_pkg::MS_PER_MIN
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] fault_level,
    input wire logic mains_zc,
    input wire logic over_200mv,
    output logic test_inject,
    output logic trip_driver,
    output logic fault_blink,
    output logic [2:0] fail_count
);

    function automatic logic [7:0] band_limit(input logic [7:0] lvl);
        logic [7:0] lim;
        lim = gfst_pkg::LIM_6MA_MS;
        if (lvl > gfst_pkg::BAND_33MA) lim = gfst_pkg::LIM_33MA_MS;
        else if (lvl >= gfst_pkg::BAND_29MA) lim = gfst_pkg::LIM_29MA_MS;
        else if (lvl >= gfst_pkg::BAND_26P5MA) lim = gfst_pkg::LIM_26P5MA_MS;
        else if (lvl >= gfst_pkg::BAND_22P5MA) lim = gfst_pkg::LIM_22P5MA_MS;
        else if (lvl >= gfst_pkg::BAND_20MA) lim = gfst_pkg::LIM_20MA_MS;
        else if (lvl >= gfst_pkg::BAND_17P5MA) lim = gfst_pkg::LIM_17P5MA_MS;
        else if (lvl >= gfst_pkg::BAND_15MA) lim = gfst_pkg::LIM_15MA_MS;
        else if (lvl >= gfst_pkg::BAND_10MA) lim = gfst_pkg::LIM_10MA_MS;
        return lim;
    endfunction : band_limit

    // Pin synchronisers: stage 1 feeds only stage 2
    logic [2:0] zc_sync_q;
    logic [2:0] hv_sync_q;
    logic zc_stable_q;
    logic hv_stable_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            zc_sync_q <= 3'h0;
            hv_sync_q <= 3'h0;
            zc_stable_q <= 1'b0;
            hv_stable_q <= 1'b0;
        end else begin
            zc_sync_q <= {zc_sync_q[1:0], mains_zc};
            hv_sync_q <= {hv_sync_q[1:0], over_200mv};
            if (zc_sync_q[1] == zc_sync_q[2]) zc_stable_q <= zc_sync_q[2];
            if (hv_sync_q[1] == hv_sync_q[2]) hv_stable_q <= hv_sync_q[2];
        end
    end
    wire zc_agree = (zc_sync_q[1] == zc_sync_q[2]);
    wire half_edge = zc_agree && (zc_sync_q[2] != zc_stable_q);
    wire hv_now = (hv_sync_q[1] == hv_sync_q[2]) ? hv_sync_q[2] : hv_stable_q;

    // Millisecond enable
    logic [23:0] div_q;
    wire ms_tick = (div_q == 24'(CYC_PER_MS - 1));
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) div_q <= gfst_pkg::WAIT_RST;
        else div_q <= ms_tick ? 24'h00_0000 : div_q + 24'h00_0001;
    end

    gfst_pkg::gfst_state_e st_q;
    logic [23:0] wait_q;
    logic [1:0] hc_q;
    logic [7:0] peak_q;
    logic [2:0] fail_q;
    logic blink_en_q;
    logic trip_q;

    wire [7:0] peak_now = (fault_level > peak_q) ? fault_level : peak_q;
    wire test_pass = (peak_q >= gfst_pkg::TEST_LOW) && (peak_q <= gfst_pkg::TEST_HIGH);
    wire judge = (st_q == gfst_pkg::GFST_JUDGE);
    wire judge_fail = judge && !test_pass;
    wire [2:0] fail_inc = (fail_q == gfst_pkg::FAIL_MAX) ? fail_q : fail_q + 3'h1;
    wire st_trip = judge_fail && (fail_inc == gfst_pkg::FAIL_MAX);
    wire test_done = (st_q == gfst_pkg::GFST_TEST) && half_edge
        && (hc_q == gfst_pkg::TEST_HALF_CYCLES - 2'h1);

    // Self-test sequencer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= gfst_pkg::GFST_WAIT;
            wait_q <= gfst_pkg::WAIT_RST;
            hc_q <= 2'h0;
            peak_q <= 8'h00;
            fail_q <= gfst_pkg::FAIL_RST;
            blink_en_q <= 1'b0;
        end else begin
            case (st_q)
                gfst_pkg::GFST_WAIT: begin
                    if (wait_q == 24'h00_0000) begin
                        st_q <= gfst_pkg::GFST_TEST;
                        hc_q <= 2'h0;
                        peak_q <= 8'h00;
                    end else if (ms_tick) begin
                        wait_q <= wait_q - 24'h00_0001;
                    end
                end
                gfst_pkg::GFST_TEST: begin
                    peak_q <= peak_now;
                    if (half_edge) hc_q <= hc_q + 2'h1;
                    if (test_done) st_q <= gfst_pkg::GFST_JUDGE;
                end
                gfst_pkg::GFST_JUDGE: begin
                    st_q <= gfst_pkg::GFST_WAIT;
                    if (test_pass) begin
                        fail_q <= gfst_pkg::FAIL_RST;
                        blink_en_q <= 1'b0;
                        wait_q <= 24'(PASS_MS);
                    end else begin
                        fail_q <= fail_inc;
                        blink_en_q <= 1'b1;
                        wait_q <= 24'(RETRY_MS);
                    end
                end
                default: st_q <= gfst_pkg::GFST_WAIT;
            endcase
        end
    end

    // Graded delay; masked while the test current is injected
    logic [7:0] gf_ms_q;
    wire grade_on = (fault_level >= gfst_pkg::BAND_6MA) && (st_q != gfst_pkg::GFST_TEST);
    wire [7:0] grade_lim = band_limit(fault_level);
    // Trip one tick early so tick phase jitter cannot exceed the limit
    wire grade_hit = grade_on && (gf_ms_q >= grade_lim - 8'h01);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) gf_ms_q <= 8'h00;
        else if (!grade_on) gf_ms_q <= 8'h00;
        else if (ms_tick && gf_ms_q != 8'hFF) gf_ms_q <= gf_ms_q + 8'h01;
    end

    // Large-fault persistence
    logic [23:0] hf_q;
    wire hf_hit = hv_now && (hf_q >= 24'(HF_CYC));
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) hf_q <= 24'h00_0000;
        else if (!hv_now) hf_q <= 24'h00_0000;
        else if (!hf_hit) hf_q <= hf_q + 24'h00_0001;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) trip_q <= 1'b0;
        else trip_q <= trip_q | st_trip | grade_hit | hf_hit;
    end

    // Indicator blink
    logic [7:0] blink_ms_q;
    logic blink_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            blink_ms_q <= 8'h00;
            blink_q <= 1'b0;
        end else if (!blink_en_q) begin
            blink_ms_q <= 8'h00;
            blink_q <= 1'b0;
        end else if (ms_tick) begin
            blink_ms_q <= (blink_ms_q == gfst_pkg::BLINK_MS - 8'h01) ? 8'h00 : blink_ms_q + 8'h01;
            if (blink_ms_q == gfst_pkg::BLINK_MS - 8'h01) blink_q <= !blink_q;
        end
    end

    assign test_inject = (st_q == gfst_pkg::GFST_TEST);
    assign trip_driver = trip_q;
    assign fault_blink = blink_q;
    assign fail_count = fail_q;

    // Assertion helpers, kept apart from the sequencer so a broken
    // half-cycle count in the sequencer cannot hide itself
    logic [1:0] chk_hc_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) chk_hc_q <= 2'h0;
        else if (!test_inject) chk_hc_q <= 2'h0;
        else if (half_edge && chk_hc_q != 2'h3) chk_hc_q <= chk_hc_q + 2'h1;
    end
    // Every legal reason to fire the trip driver
    wire trip_set = st_trip | grade_hit | hf_hit;

    a_trip_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
        trip_driver |=> trip_driver) else $error("trip driver released");
    a_hf_trip: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (hv_now && hf_q == 24'(HF_CYC)) |=> trip_driver) else $error("large fault no trip");
    a_grade_trip: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (grade_on && gf_ms_q >= grade_lim) |=> trip_driver) else $error("graded trip late");
    a_test_two_half: assert property (@(posedge clk_sys) disable iff (!arst_n)
        judge |-> chk_hc_q == 2'h2)
        else $error("judged before two half cycles");
    a_fail_blink: assert property (@(posedge clk_sys) disable iff (!arst_n)
        judge_fail |=> blink_en_q ##[1:2] $stable(fail_q)) else $error("blink not enabled");
    a_retry_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
        judge_fail |=> (wait_q == 24'(RETRY_MS)) && st_q == gfst_pkg::GFST_WAIT)
        else $error("retry interval wrong");
    a_seven_trip: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (judge_fail && fail_q == 3'h6) |=> trip_driver && fail_count == 3'h7)
        else $error("seventh failure no trip");
    a_pass_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (judge && test_pass) |=> fail_count == 3'h0 && wait_q == 24'(PASS_MS) && !blink_en_q)
        else $error("pass did not reset");

    // Output guards
    a_blink_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !blink_en_q |=> !fault_blink)
        else $error("indicator blinks while disabled");
    a_count_sat: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (judge_fail && fail_count == 3'h7) |=> fail_count == 3'h7)
        else $error("failure count wrapped");
    // A trip with no cause would be a nuisance trip in the field
    a_trip_cause: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(trip_driver) |-> $past(trip_set)) else $error("trip without cause");
endmodule : gfst_top
